// ==== rtl/sfr_map_pkg.sv ====
`default_nettype none
package sfr_map_pkg;

    localparam logic [7:0] ADDR_POINTER_LOW       = 8'h82;
    localparam logic [7:0] ADDR_POINTER_HIGH      = 8'h83;
    localparam logic [7:0] ADDR_CONV0_CONTROL     = 8'h8E;
    localparam logic [7:0] ADDR_CPU_CLOCK_DIVIDER = 8'h95;
    localparam logic [7:0] ADDR_CONV1_CONTROL     = 8'h97;
    localparam logic [7:0] ADDR_CONV_MODE_B       = 8'hA1;
    localparam logic [7:0] ADDR_AUXILIARY         = 8'hA2;
    localparam logic [7:0] ADDR_CONV_INPUT_SELECT = 8'hA3;
    localparam logic [7:0] ADDR_COMPARATOR1       = 8'hAC;
    localparam logic [7:0] ADDR_COMPARATOR2       = 8'hAD;
    localparam logic [7:0] ADDR_CONV1_BOUND_LOW   = 8'hBC;
    localparam logic [7:0] ADDR_BAUD_GEN_CONTROL  = 8'hBD;
    localparam logic [7:0] ADDR_BAUD_RATE_LOW     = 8'hBE;
    localparam logic [7:0] ADDR_BAUD_RATE_HIGH    = 8'hBF;
    localparam logic [7:0] ADDR_CONV_MODE_A       = 8'hC0;
    localparam logic [7:0] ADDR_CONV1_BOUND_HIGH  = 8'hC4;
    localparam logic [7:0] ADDR_CONV1_RESULT0     = 8'hD5;
    localparam logic [7:0] ADDR_CONV1_RESULT1     = 8'hD6;
    localparam logic [7:0] ADDR_CONV1_RESULT2     = 8'hD7;
    localparam logic [7:0] ADDR_TWO_WIRE_CONTROL  = 8'hD8;
    localparam logic [7:0] ADDR_TWO_WIRE_DATA     = 8'hDA;
    localparam logic [7:0] ADDR_TWO_WIRE_OWN_ADDR = 8'hDB;
    localparam logic [7:0] ADDR_TWO_WIRE_CLK_LOW  = 8'hDC;
    localparam logic [7:0] ADDR_TWO_WIRE_CLK_HIGH = 8'hDD;
    localparam logic [7:0] ADDR_ACCUMULATOR       = 8'hE0;
    localparam logic [7:0] ADDR_FLASH_CONTROL     = 8'hE4;
    localparam logic [7:0] ADDR_FLASH_DATA        = 8'hE5;
    localparam logic [7:0] ADDR_FLASH_ADDR_LOW    = 8'hE6;
    localparam logic [7:0] ADDR_FLASH_ADDR_HIGH   = 8'hE7;
    localparam logic [7:0] ADDR_B_REGISTER        = 8'hF0;
    localparam logic [7:0] ADDR_CONV0_RESULT3     = 8'hF4;
    localparam logic [7:0] ADDR_CONV1_RESULT3     = 8'hF5;

    localparam int unsigned NUM_REGS = 32;

    // ordered table of addresses, index = storage slot
    localparam logic [NUM_REGS*8-1:0] REG_ADDR_TABLE = {
        ADDR_CONV1_RESULT3, ADDR_CONV0_RESULT3, ADDR_B_REGISTER, ADDR_FLASH_ADDR_HIGH,
        ADDR_FLASH_ADDR_LOW, ADDR_FLASH_DATA, ADDR_FLASH_CONTROL, ADDR_ACCUMULATOR,
        ADDR_TWO_WIRE_CLK_HIGH, ADDR_TWO_WIRE_CLK_LOW, ADDR_TWO_WIRE_OWN_ADDR,
        ADDR_TWO_WIRE_DATA, ADDR_TWO_WIRE_CONTROL, ADDR_CONV1_RESULT2, ADDR_CONV1_RESULT1,
        ADDR_CONV1_RESULT0, ADDR_CONV1_BOUND_HIGH, ADDR_CONV_MODE_A, ADDR_BAUD_RATE_HIGH,
        ADDR_BAUD_RATE_LOW, ADDR_BAUD_GEN_CONTROL, ADDR_CONV1_BOUND_LOW, ADDR_COMPARATOR2,
        ADDR_COMPARATOR1, ADDR_CONV_INPUT_SELECT, ADDR_AUXILIARY, ADDR_CONV_MODE_B,
        ADDR_CONV1_CONTROL, ADDR_CPU_CLOCK_DIVIDER, ADDR_CONV0_CONTROL, ADDR_POINTER_HIGH,
        ADDR_POINTER_LOW
    };

    // slot of 0xE4 in the table above, counted from the low end
    localparam int unsigned SLOT_FLASH_CONTROL = 25;

    localparam logic [7:0] RESET_ZERO              = 8'h00;
    localparam logic [7:0] RESET_CONV1_BOUND_HIGH  = 8'hFF;
    localparam logic [7:0] RESET_FLASH_STATUS      = 8'h70;
    localparam logic [7:0] RESET_FLASH_COMMAND     = 8'h00;

    // bits forced to zero on write, per slot (fixed-zero and reserved positions)
    localparam logic [7:0] ZERO_MASK_AUXILIARY     = 8'h06;
    localparam logic [7:0] ZERO_MASK_TWO_WIRE_CTRL = 8'h82;

    // flash status bit positions
    localparam int unsigned FLASH_BUSY_BIT         = 7;
    localparam int unsigned FLASH_HVA_BIT          = 3;
    localparam int unsigned FLASH_HVE_BIT          = 2;
    localparam int unsigned FLASH_SV_BIT           = 1;
    localparam int unsigned FLASH_OI_BIT           = 0;

    typedef struct packed {
        logic       write_strobe;
        logic       read_strobe;
        logic [7:0] address;
        logic [7:0] write_data;
    } sfr_request_t;

    typedef struct packed {
        logic       bit_write;
        logic [7:0] bit_address;
        logic       bit_value;
    } bit_request_t;

    typedef struct packed {
        logic       busy;
        logic       high_voltage_active;
        logic       high_voltage_error;
        logic       security_violation;
        logic       operation_interrupted;
    } flash_status_t;

endpackage : sfr_map_pkg

`default_nettype wire

// ==== rtl/sfr_map_access_rules.sv ====
// Notes on behaviour
// - reserved bits are written as zero and their read value is not promised.
// - bits fixed at zero are written as zero and always read back as zero.
// - bits fixed at one are written as one and always read back as one; no stored bit is forced to one, only flash status bits 6..4 read as one.
// - the flash control address reads status (reset 0x70) but a write loads a command.
// - the upper bound register of converter one resets to all ones, the rest to zero.
// - accumulator, B and two-wire control are bit addressable at register plus index.
// - the sixteen-bit pointer is split into a high byte and a low byte one below.
`timescale 1ns/1ps
`default_nettype none

module sfr_map_access_rules
    import sfr_map_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          srst,
    input  wire sfr_request_t  request,
    input  wire bit_request_t  bit_request,
    input  wire flash_status_t flash_status,
    output logic [7:0]         read_data,
    output logic [7:0]         flash_command_code,
    output logic               flash_command_valid,
    output logic [15:0]        sixteen_bit_pointer
);

    // address decode into slot index
    function automatic logic [NUM_REGS-1:0] decode_slot(input logic [7:0] addr);
        logic [NUM_REGS-1:0] hit;
        hit = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            hit[i] = (REG_ADDR_TABLE[i*8 +: 8] == addr);
        end
        return hit;
    endfunction : decode_slot

    // bit-address decode: base register and index
    function automatic logic [2:0] decode_bit_reg(input logic [7:0] baddr);
        logic [2:0] sel;
        sel = 3'b000;
        if (baddr[7:3] == ADDR_ACCUMULATOR[7:3]) sel[0] = 1'b1;
        if (baddr[7:3] == ADDR_B_REGISTER[7:3]) sel[1] = 1'b1;
        if (baddr[7:3] == ADDR_TWO_WIRE_CONTROL[7:3]) sel[2] = 1'b1;
        return sel;
    endfunction : decode_bit_reg

    function automatic logic [7:0] reset_value(input int unsigned slot);
        logic [7:0] v;
        v = RESET_ZERO;
        if (REG_ADDR_TABLE[slot*8 +: 8] == ADDR_CONV1_BOUND_HIGH) v = RESET_CONV1_BOUND_HIGH;
        return v;
    endfunction : reset_value

    function automatic logic [7:0] zero_mask(input int unsigned slot);
        logic [7:0] m;
        m = 8'h00;
        if (REG_ADDR_TABLE[slot*8 +: 8] == ADDR_AUXILIARY) m = ZERO_MASK_AUXILIARY;
        if (REG_ADDR_TABLE[slot*8 +: 8] == ADDR_TWO_WIRE_CONTROL) m = ZERO_MASK_TWO_WIRE_CTRL;
        return m;
    endfunction : zero_mask

    logic [NUM_REGS-1:0] write_hit;
    logic [NUM_REGS-1:0] read_hit;
    logic [2:0]          bit_sel;
    logic [2:0]          bit_index;
    logic [7:0]          reg_q [NUM_REGS];
    logic [7:0]          read_mux;
    logic [7:0]          flash_status_byte;
    logic [7:0]          read_data_q;
    logic [7:0]          command_q;
    logic                command_valid_q;
    logic                flash_write;

    assign write_hit = request.write_strobe ? decode_slot(request.address) : '0;
    assign read_hit  = request.read_strobe  ? decode_slot(request.address) : '0;
    assign bit_sel   = bit_request.bit_write ? decode_bit_reg(bit_request.bit_address) : 3'b000;
    assign bit_index = bit_request.bit_address[2:0];
    assign flash_write = write_hit[SLOT_FLASH_CONTROL];

    // status view of flash control; bits 6..4 read as one
    assign flash_status_byte = RESET_FLASH_STATUS | {flash_status.busy, 3'b000,
                                flash_status.high_voltage_active,
                                flash_status.high_voltage_error,
                                flash_status.security_violation,
                                flash_status.operation_interrupted};

    // per-slot storage; flash control slot keeps no storage
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            if (g == SLOT_FLASH_CONTROL) begin : g_flash
                assign reg_q[g] = flash_status_byte;
            end else begin : g_store
                localparam logic [7:0] KEEP_ZERO = zero_mask(g);
                logic [7:0] d;
                logic [7:0] q;
                always_comb begin
                    d = q;
                    if (write_hit[g]) d = request.write_data & ~KEEP_ZERO;
                    if (REG_ADDR_TABLE[g*8 +: 8] == ADDR_ACCUMULATOR && bit_sel[0])
                        d[bit_index] = bit_request.bit_value;
                    if (REG_ADDR_TABLE[g*8 +: 8] == ADDR_B_REGISTER && bit_sel[1])
                        d[bit_index] = bit_request.bit_value;
                    if (REG_ADDR_TABLE[g*8 +: 8] == ADDR_TWO_WIRE_CONTROL && bit_sel[2])
                        d[bit_index] = bit_request.bit_value & ~KEEP_ZERO[bit_index];
                end
                always_ff @(posedge clock) begin
                    if (srst) q <= reset_value(g);
                    else q <= d;
                end
                assign reg_q[g] = q;
            end
        end
    endgenerate

    always_comb begin
        read_mux = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (read_hit[i]) read_mux = reg_q[i];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            read_data_q     <= RESET_ZERO;
            command_q       <= RESET_FLASH_COMMAND;
            command_valid_q <= 1'b0;
        end else begin
            read_data_q     <= read_mux;
            command_valid_q <= flash_write;
            if (flash_write) command_q <= request.write_data;
        end
    end

    logic [15:0] pointer_q;
    always_ff @(posedge clock) begin
        if (srst) pointer_q <= {RESET_ZERO, RESET_ZERO};
        else pointer_q <= {reg_q[1], reg_q[0]};
    end

    assign read_data           = read_data_q;
    assign flash_command_code  = command_q;
    assign flash_command_valid = command_valid_q;
    assign sixteen_bit_pointer = pointer_q;

endmodule : sfr_map_access_rules

`default_nettype wire

// ==== bench/sfr_map_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfr_map_props
    import sfr_map_pkg::*;
(
    input wire logic          clock,
    input wire logic          srst,
    input wire sfr_request_t  request,
    input wire bit_request_t  bit_request,
    input wire flash_status_t flash_status,
    input wire logic [7:0]    read_data,
    input wire logic [7:0]    flash_command_code,
    input wire logic          flash_command_valid,
    input wire logic [15:0]   sixteen_bit_pointer
);
    logic hit_reg;
    wire  rd = request.read_strobe;
    wire  wr = request.write_strobe;
    wire  [7:0] ad = request.address;
    always_comb begin
        hit_reg = 1'b0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (REG_ADDR_TABLE[i*8 +: 8] == ad) hit_reg = 1'b1;
        end
    end
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (srst);
    AST_UNDEF_READ_ZERO: assert property (rd && !hit_reg |=> read_data == 8'h00)
        else $error("undefined address read not zero");
    AST_FLASH_STATUS: assert property (rd && ad == 8'hE4 |=> read_data ==
        {$past(flash_status.busy), 3'b111, $past(flash_status[3:0])}) else $error("flash status");
    AST_CMD_PULSE: assert property (wr && ad == 8'hE4 |=> flash_command_valid
        && flash_command_code == $past(request.write_data)) else $error("command not loaded");
    AST_CMD_QUIET: assert property (!(wr && ad == 8'hE4) |=> !flash_command_valid)
        else $error("stray command pulse");
    AST_PTR_LOW: assert property (wr && ad == 8'h82 |-> ##2
        sixteen_bit_pointer[7:0] == $past(request.write_data, 2)) else $error("pointer low");
    AST_PTR_HIGH: assert property (wr && ad == 8'h83 |-> ##2
        sixteen_bit_pointer[15:8] == $past(request.write_data, 2)) else $error("pointer high");
    AST_AUX_ZERO: assert property (rd && ad == 8'hA2 |=> (read_data & 8'h04) == 8'h00)
        else $error("fixed zero bit read as one");
    AST_TWI_ZERO: assert property (rd && ad == 8'hD8 |=> (read_data & 8'h82) == 8'h00)
        else $error("two-wire reserved bits");
    AST_BIT_WRITE: assert property (bit_request.bit_write && !wr ##1 rd && !bit_request.bit_write
        && ad == {$past(bit_request.bit_address[7:3]), 3'b000} |=> read_data[$past(
        bit_request.bit_address[2:0], 2)] == $past(bit_request.bit_value, 2)) else $error("bit");
    cover property (rd && ad == 8'hE4);
    cover property (wr && ad == 8'hE4);
    cover property (wr && ad == 8'h82);
    cover property (bit_request.bit_write && !wr ##1 rd && !bit_request.bit_write);
endmodule : sfr_map_props
bind sfr_map_access_rules sfr_map_props sfr_map_props_i (.clock(clock), .srst(srst),
    .request(request), .bit_request(bit_request), .flash_status(flash_status),
    .read_data(read_data), .flash_command_code(flash_command_code),
    .flash_command_valid(flash_command_valid), .sixteen_bit_pointer(sixteen_bit_pointer));
`default_nettype wire

// ==== bench/core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_model
    import sfr_map_pkg::*;
(
    input  wire logic       clock,
    output var sfr_request_t request,
    output var bit_request_t bit_request
);
    // writable bits per address, reserved and fixed-zero cleared
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            ADDR_CONV0_CONTROL: return 8'h04;
            ADDR_CONV_INPUT_SELECT, ADDR_CONV_MODE_A: return 8'hF0;
            ADDR_CONV_MODE_B: return 8'hEE;
            ADDR_AUXILIARY: return 8'hF9;
            ADDR_BAUD_GEN_CONTROL: return 8'h03;
            ADDR_COMPARATOR1, ADDR_COMPARATOR2: return 8'h3F;
            ADDR_TWO_WIRE_CONTROL: return 8'h7D;
            default: return 8'hFF;
        endcase
    endfunction : wmask
    initial begin
        request = '0;
        bit_request = '0;
    end
    // undefined addresses only when the bench asks for them
    task automatic drive(input sfr_request_t r, input bit_request_t b);
        logic [7:0] wm;
        @(posedge clock);
        wm = wmask({b.bit_address[7:3], 3'b000});
        r.write_data &= wmask(r.address);
        b.bit_value &= wm[b.bit_address[2:0]];
        request <= r;
        bit_request <= b;
    endtask : drive
endmodule : core_model
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench import sfr_map_pkg::*;;
    logic clock = 1'b0;
    logic srst = 1'b1;
    flash_status_t flash_status = '0, ps;
    sfr_request_t request, pr;
    bit_request_t bit_request, pb;
    logic [7:0] read_data, flash_command_code, a, m [256];
    logic flash_command_valid;
    logic [15:0] sixteen_bit_pointer;
    logic [31:0] k;
    int mismatches = 0, tests_run = 0, cycles = 0;
    integer seed = 32'h7547D51A;
    initial begin
        forever #20 clock = ~clock;
    end
    core_model core_model_i (.clock(clock), .request(request), .bit_request(bit_request));
    sfr_map_access_rules sfr_map_access_rules_i (.clock(clock), .srst(srst), .request(request),
        .bit_request(bit_request), .flash_status(flash_status), .read_data(read_data),
        .flash_command_code(flash_command_code), .flash_command_valid(flash_command_valid),
        .sixteen_bit_pointer(sixteen_bit_pointer));
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    function automatic logic is_reg(input logic [7:0] x);
        for (int i = 0; i < NUM_REGS; i++) begin
            if (REG_ADDR_TABLE[i*8 +: 8] == x) return 1'b1;
        end
        return 1'b0;
    endfunction : is_reg
    function automatic logic [7:0] expect_rd(input logic [7:0] x, input flash_status_t s);
        if (!is_reg(x)) return 8'h00;
        if (x == ADDR_FLASH_CONTROL) return {s.busy, 3'b111, s[3:0]};
        if (x == ADDR_AUXILIARY) return m[x] & 8'hF9;
        if (x == ADDR_TWO_WIRE_CONTROL) return m[x] & 8'h7D;
        return m[x];
    endfunction : expect_rd
    function automatic sfr_request_t mk(input logic w, r, input logic [7:0] x, d);
        return {w, r, x, d};
    endfunction : mk
    task automatic do_reset;
        core_model_i.drive('0, '0);
        srst <= 1'b1;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        foreach (m[i]) m[i] = 8'h00;
        m[8'hC4] = 8'hFF;
        pr = '0;
        pb = '0;
    endtask : do_reset
    task automatic cyc(input sfr_request_t r, input bit_request_t b, input flash_status_t s);
        core_model_i.drive(r, b);
        flash_status <= s;
        #1;
        chk(sixteen_bit_pointer, {m[8'h83], m[8'h82]});
        chk(read_data, pr.read_strobe ? expect_rd(pr.address, ps) : 8'h00);
        chk(flash_command_valid, pr.write_strobe && pr.address == 8'hE4);
        if (flash_command_valid === 1'b1) chk(flash_command_code, pr.write_data);
        if (pr.write_strobe && is_reg(pr.address) && pr.address != 8'hE4)
            m[pr.address] = pr.write_data;
        if (pb.bit_write) m[{pb.bit_address[7:3], 3'b000}][pb.bit_address[2:0]] = pb.bit_value;
        pr = core_model_i.request;
        pb = core_model_i.bit_request;
        ps = s;
    endtask : cyc
    task automatic sweep;
        for (int i = 128; i < 256; i++) cyc(mk(1'b0, 1'b1, i[7:0], 8'h00), '0, '0);
        cyc('0, '0, '0);
        $display("sweep done");
    endtask : sweep
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        do_reset();
        sweep();
        cyc(mk(1'b1, 1'b0, 8'h82, 8'h5A), '0, '0);
        cyc(mk(1'b1, 1'b0, 8'h83, 8'hA5), '0, '0);
        cyc(mk(1'b1, 1'b0, 8'hE4, 8'h3C), '0, 5'h1F);
        cyc(mk(1'b0, 1'b1, 8'hE4, 8'h00), '0, 5'h0A);
        cyc(mk(1'b1, 1'b0, 8'hE0, 8'h00), {1'b1, 8'hE3, 1'b1}, '0);
        cyc(mk(1'b0, 1'b1, 8'hE0, 8'h00), {1'b1, 8'hF5, 1'b1}, '0);
        cyc(mk(1'b0, 1'b1, 8'hF0, 8'h00), '0, '0);
        cyc('0, {1'b1, 8'hF2, 1'b1}, '0);
        cyc(mk(1'b0, 1'b1, 8'hF0, 8'h00), '0, '0);
        cyc(mk(1'b1, 1'b0, 8'h81, 8'hFF), '0, '0);
        cyc(mk(1'b0, 1'b1, 8'h81, 8'h00), '0, '0);
        cyc('0, '0, '0);
        cyc('0, '0, '0);
        $display("corners done");
        repeat (400) begin
            a = 8'h80 | 8'($random(seed));
            k = $random(seed);
            cyc(mk(k[0] & ~k[1], k[1], a, 8'($random(seed))), {k[2], (k[5] ? 8'hE0 : k[4] ?
                8'hF0 : 8'hD8) | 8'(k[8:6]), k[3]}, 5'($random(seed)));
        end
        cyc('0, '0, '0);
        $display("random done");
        do_reset();
        sweep();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
